// >>> rtl/drs_map.vh
`ifndef DRS_MAP_VH
`define DRS_MAP_VH
// ---------------------------------------------------------------
// register byte offsets (chosen layout, one aligned word each)
// ---------------------------------------------------------------
`define DRS_OFF_CF_LO 8'h00
`define DRS_OFF_CF_HI 8'h04
`define DRS_OFF_OF_LO 8'h08
`define DRS_OFF_OF_HI 8'h0C
`define DRS_OFF_SF_LO 8'h10
`define DRS_OFF_SF_HI 8'h14
`define DRS_OFF_CFG13 8'h18
`define DRS_OFF_CFG14 8'h1C
`define DRS_OFF_STAT 8'h20
// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define DRS_CF_RST 48'h4000_0000_0000
`define DRS_CFG13_RST 8'h40
`define DRS_CFG14_RST 8'h00
`define DRS_DAC_MID 14'h2000
`define DRS_SF_EN_BIT 6
`define DRS_OF_EN_BIT 7
`define DRS_WORD_W 48
`define DRS_DAC_W 14
// ---------------------------------------------------------------
// timing and response codes
// ---------------------------------------------------------------
`define DRS_OUT_LAT 4'hB
`define DRS_RESP_OKAY 2'h0
`define DRS_RESP_SLVERR 2'h2
`endif

// >>> rtl/drs_reset_sequencer.v
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "drs_map.vh"
module drs_reset_sequencer (
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // axi4-lite write address
    input wire [7:0] awaddr,
    input wire awvalid,
    output reg awready,
    // axi4-lite write data
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    // axi4-lite write response
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // axi4-lite read address
    input wire [7:0] araddr,
    input wire arvalid,
    output reg arready,
    // axi4-lite read data
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // synthesis outputs
    output reg [13:0] dacCode,
    output reg outReady
);

// ---------------------------------------------------------------
// state
// ---------------------------------------------------------------
reg [47:0] cfWord_q; // center frequency word
reg [47:0] ofWord_q; // offset frequency word, no reset value
reg [47:0] sfWord_q; // serial frequency word, no reset value
reg [7:0] cfg13_q; // config 13, serial/offset enables
reg [7:0] cfg14_q; // config 14, host must set
reg [47:0] phase_q; // phase accumulator
reg [47:0] step_q; // registered frequency sum
reg [3:0] latCnt_q; // cycles since reset release
reg wrOpen_q; // writes allowed, set one edge after release
reg awHeld_q; // address captured
reg wHeld_q; // data captured
reg [7:0] awAddr_q; // captured write address
reg [31:0] wData_q; // captured write data
reg [3:0] wStrb_q; // captured strobes
wire [13:0] sineCode; // amplitude from phase
wire doWrite; // both halves present, commit now
wire [47:0] stepSum; // frequency sum before register

// ---------------------------------------------------------------
// write gate
// ---------------------------------------------------------------
// the flop clears asynchronously and sets on the first edge seen
// after release, so nothing written on that edge lands
// a host that raises its request while reset is still low is only
// served from the second edge; awready and wready stay low until then
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        wrOpen_q <= 1'b0;
    end else begin
        wrOpen_q <= 1'b1;
    end
end

// ---------------------------------------------------------------
// axi write channel: address and data in either order
// ---------------------------------------------------------------
// a write commits once both halves are held and no answer is pending;
// a new address or data beat may be captured while bvalid still waits,
// so the host may overlap its next request with the response
assign doWrite = awHeld_q && wHeld_q && !bvalid;

// ready flags are one-cycle pulses; the held flags block a second
// capture until the held write has been committed
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        awready <= 1'b0;
        wready <= 1'b0;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        awAddr_q <= 8'h00;
        wData_q <= 32'h0000_0000;
        wStrb_q <= 4'h0;
        bvalid <= 1'b0;
        bresp <= `DRS_RESP_OKAY;
    end else begin
        awready <= 1'b0;
        wready <= 1'b0;
        // take address when free and gate open
        if (awvalid && !awHeld_q && !awready && wrOpen_q) begin
            awready <= 1'b1;
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
        end
        // take data likewise
        if (wvalid && !wHeld_q && !wready && wrOpen_q) begin
            wready <= 1'b1;
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end
        // commit then answer
        if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bvalid <= 1'b1;
            case (awAddr_q)
                `DRS_OFF_CF_LO, `DRS_OFF_CF_HI, `DRS_OFF_OF_LO,
                `DRS_OFF_OF_HI, `DRS_OFF_SF_LO, `DRS_OFF_SF_HI,
                `DRS_OFF_CFG13, `DRS_OFF_CFG14: begin
                    bresp <= `DRS_RESP_OKAY;
                end
                default: begin
                    bresp <= `DRS_RESP_SLVERR; // unmapped or read-only
                end
            endcase
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end
end

// ---------------------------------------------------------------
// control registers (byte lanes honoured)
// ---------------------------------------------------------------
// offset and serial words have no reset: their content is
// undefined after reset, only their enables are forced
// upper halves carry bits 47:32 in data bits 15:0; lanes 2 and 3 of
// an upper-half write are ignored
always @(posedge mclk) begin
    if (doWrite && wrOpen_q) begin
        case (awAddr_q)
            `DRS_OFF_OF_LO: begin
                if (wStrb_q[0]) ofWord_q[7:0] <= wData_q[7:0];
                if (wStrb_q[1]) ofWord_q[15:8] <= wData_q[15:8];
                if (wStrb_q[2]) ofWord_q[23:16] <= wData_q[23:16];
                if (wStrb_q[3]) ofWord_q[31:24] <= wData_q[31:24];
            end
            `DRS_OFF_OF_HI: begin
                if (wStrb_q[0]) ofWord_q[39:32] <= wData_q[7:0];
                if (wStrb_q[1]) ofWord_q[47:40] <= wData_q[15:8];
            end
            `DRS_OFF_SF_LO: begin
                if (wStrb_q[0]) sfWord_q[7:0] <= wData_q[7:0];
                if (wStrb_q[1]) sfWord_q[15:8] <= wData_q[15:8];
                if (wStrb_q[2]) sfWord_q[23:16] <= wData_q[23:16];
                if (wStrb_q[3]) sfWord_q[31:24] <= wData_q[31:24];
            end
            `DRS_OFF_SF_HI: begin
                if (wStrb_q[0]) sfWord_q[39:32] <= wData_q[7:0];
                if (wStrb_q[1]) sfWord_q[47:40] <= wData_q[15:8];
            end
            default: begin
            end
        endcase
    end
end

// reset-valued registers
// centre word loads the quarter-rate value, config 13 enables only the
// serial path; the host must still write config 14 after every reset
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        cfWord_q <= `DRS_CF_RST;
        cfg13_q <= `DRS_CFG13_RST;
        cfg14_q <= `DRS_CFG14_RST;
    end else if (doWrite && wrOpen_q) begin
        case (awAddr_q)
            `DRS_OFF_CF_LO: begin
                if (wStrb_q[0]) cfWord_q[7:0] <= wData_q[7:0];
                if (wStrb_q[1]) cfWord_q[15:8] <= wData_q[15:8];
                if (wStrb_q[2]) cfWord_q[23:16] <= wData_q[23:16];
                if (wStrb_q[3]) cfWord_q[31:24] <= wData_q[31:24];
            end
            `DRS_OFF_CF_HI: begin
                if (wStrb_q[0]) cfWord_q[39:32] <= wData_q[7:0];
                if (wStrb_q[1]) cfWord_q[47:40] <= wData_q[15:8];
            end
            `DRS_OFF_CFG13: begin
                if (wStrb_q[0]) cfg13_q <= wData_q[7:0];
            end
            `DRS_OFF_CFG14: begin
                if (wStrb_q[0]) cfg14_q <= wData_q[7:0];
            end
            default: begin
            end
        endcase
    end
end

// ---------------------------------------------------------------
// axi read channel
// ---------------------------------------------------------------
// reads are served in one cycle from the live registers; arready and
// rvalid rise together, and a new address is refused while rvalid
// waits. reads pass the write gate: they change nothing
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        arready <= 1'b0;
        rvalid <= 1'b0;
        rdata <= 32'h0000_0000;
        rresp <= `DRS_RESP_OKAY;
    end else begin
        arready <= 1'b0;
        if (arvalid && !arready && !rvalid) begin
            arready <= 1'b1;
            rvalid <= 1'b1;
            rresp <= `DRS_RESP_OKAY;
            case (araddr)
                `DRS_OFF_CF_LO: rdata <= cfWord_q[31:0];
                `DRS_OFF_CF_HI: rdata <= {16'h0000, cfWord_q[47:32]};
                `DRS_OFF_OF_LO: rdata <= ofWord_q[31:0];
                `DRS_OFF_OF_HI: rdata <= {16'h0000, ofWord_q[47:32]};
                `DRS_OFF_SF_LO: rdata <= sfWord_q[31:0];
                `DRS_OFF_SF_HI: rdata <= {16'h0000, sfWord_q[47:32]};
                `DRS_OFF_CFG13: rdata <= {24'h00_0000, cfg13_q};
                `DRS_OFF_CFG14: rdata <= {24'h00_0000, cfg14_q};
                // status: [5] output live, [4] write gate, [3:0] edges since release
                `DRS_OFF_STAT: rdata <= {26'h0, outReady, wrOpen_q, latCnt_q};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= `DRS_RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
end

// ---------------------------------------------------------------
// frequency sum and phase accumulator
// ---------------------------------------------------------------
// disabled words are zeroed before the add; 48-bit wrap is modulo
// the registered step costs one cycle of latency but keeps the
// three-word adder out of the accumulator path
assign stepSum = cfWord_q
    + (cfg13_q[`DRS_OF_EN_BIT] ? ofWord_q : 48'h0000_0000_0000)
    + (cfg13_q[`DRS_SF_EN_BIT] ? sfWord_q : 48'h0000_0000_0000);

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        step_q <= 48'h0000_0000_0000;
        phase_q <= 48'h0000_0000_0000;
    end else begin
        step_q <= stepSum;
        phase_q <= phase_q + step_q;
    end
end

// coarse amplitude: folded triangle of the top phase bits keeps the
// block small; a real sine table would replace this mapping
// the inversion sits inside the concatenation so it stays 13 bits wide
assign sineCode = phase_q[47] ? {~phase_q[46:34], 1'b0} : {phase_q[46:34], 1'b0};

// ---------------------------------------------------------------
// release latency counter and dac register
// ---------------------------------------------------------------
// counts edges after release and stops at the output latency; outReady
// rises on the edge at which the counter reaches its end, so the first
// live dac sample and the ready flag appear together
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        latCnt_q <= 4'h0;
        outReady <= 1'b0;
    end else if (latCnt_q != `DRS_OUT_LAT) begin
        latCnt_q <= latCnt_q + 4'h1;
        outReady <= (latCnt_q == (`DRS_OUT_LAT - 4'h1));
    end
end

// new code every cycle; held at midscale until the pipeline shows
// the reset state
// midscale is the dac's zero; holding it keeps the output quiet while
// the accumulator pipeline refills after reset
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        dacCode <= `DRS_DAC_MID;
    end else begin
        dacCode <= (latCnt_q == (`DRS_OUT_LAT - 4'h1) || outReady) ?
            sineCode : `DRS_DAC_MID;
    end
end

endmodule // drs_reset_sequencer

// >>> dv/drs_reset_sequencer_chk_sva.sv
`timescale 1ns/1ps
`include "drs_map.vh"
module drs_reset_sequencer_chk (
    input wire mclk, arst_n,
    input wire awready, wready, bvalid, bready, arready, rvalid, rready,
    input wire [1:0] bresp, rresp,
    input wire [31:0] rdata,
    input wire [13:0] dacCode,
    input wire outReady
);
    reg [3:0] relCnt_q; // edges since release, held at 15 so it never wraps
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) relCnt_q <= 4'h0;
        else if (relCnt_q != 4'hF) relCnt_q <= relCnt_q + 4'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_outLat; outReady == (relCnt_q >= 4'hB); endproperty
    a_outLat: assert property (p_outLat) else $error("output ready off count");
    property p_dacMid; !outReady |-> dacCode == 14'h2000; endproperty
    a_dacMid: assert property (p_dacMid) else $error("dac not midscale");
    property p_gate; relCnt_q < 4'h2 |-> !awready && !wready; endproperty
    a_gate: assert property (p_gate) else $error("write taken too early");
    property p_bHold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_bHold: assert property (p_bHold) else $error("write answer dropped");
    property p_rHold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_rHold: assert property (p_rHold) else $error("read answer dropped");
    property p_arAns; arready |-> rvalid; endproperty
    a_arAns: assert property (p_arAns) else $error("read data late");
    property p_errZero; rvalid && rresp == `DRS_RESP_SLVERR |-> rdata == 32'h0; endproperty
    a_errZero: assert property (p_errZero) else $error("refused read data");
    property p_aPulse; awready |=> !awready; endproperty
    a_aPulse: assert property (p_aPulse) else $error("awready not a pulse");
    c_live: cover property ($rose(outReady));
    c_wrDone: cover property (bvalid && bready);
    c_rdErr: cover property (rvalid && rready && rresp == `DRS_RESP_SLVERR);
endmodule // drs_reset_sequencer_chk
bind drs_reset_sequencer drs_reset_sequencer_chk u_chk (.*);

// >>> dv/drs_host.sv
`timescale 1ns/1ps
// slow host: answers are acknowledged one cycle late to exercise holding
module drs_host (
    // clock and reset
    input wire mclk,
    output reg arst_n = 1'b0,
    // master side of the register bus
    output reg [7:0] awaddr = 8'h00, araddr = 8'h00,
    output reg [31:0] wdata = 32'h0,
    output reg [3:0] wstrb = 4'hF,
    output reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0,
    // slave answers
    input wire awready, wready, bvalid, arready, rvalid,
    input wire [1:0] bresp, rresp,
    input wire [31:0] rdata
);
    reg hang = 1'b0; // a bounded wait ran out
    reg done;
    integer n;
    // low across 16 edges, released just after an edge
    task rst;
        begin
            arst_n <= 1'b0;
            repeat (16) @(posedge mclk);
            arst_n <= 1'b1;
        end
    endtask
    // one transfer; released lines show the inverse so stale values cannot pass
    task xfer(input wrOp, input [7:0] a, input [31:0] d, output [31:0] q, output [1:0] resp);
        begin
            @(posedge mclk);
            if (wrOp) {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
            else {araddr, arvalid} <= {a, 1'b1};
            answer(wrOp, a, d, q, resp);
        end
    endtask
    // write raised while reset is low; it must wait for the gate to open
    task rstWrite(input [7:0] a, input [31:0] d, output [1:0] resp);
        reg [31:0] q;
        begin
            @(posedge mclk);
            {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
            rst;
            answer(1'b1, a, d, q, resp);
        end
    endtask
    // wait for the answer, acknowledging it one cycle late; n counts edges
    task answer(input wrOp, input [7:0] a, input [31:0] d, output [31:0] q, output [1:0] resp);
        begin
            done = 1'b0;
            for (n = 0; n < 40 && !done; n = n + 1) begin
                @(posedge mclk);
                if (awready) {awvalid, awaddr} <= {1'b0, ~a};
                if (wready) {wvalid, wdata} <= {1'b0, ~d};
                if (arready) {arvalid, araddr} <= {1'b0, ~a};
                done = (bvalid && bready) || (rvalid && rready);
                q = rdata;
                resp = wrOp ? bresp : rresp;
                bready <= bvalid && !done;
                rready <= rvalid && !done;
            end
            hang = hang | !done;
        end
    endtask
endmodule // drs_host

// >>> dv/drs_reset_sequencer_tb.sv
`timescale 1ns/1ps
`include "drs_map.vh"
`define CHK(nm, ex, got) begin testsRun = testsRun + 1; if ((got) !== (ex)) begin \
    errTotal = errTotal + 1; $display("Error %s expected %h seen %h", nm, ex, got); end end
module drs_reset_sequencer_tb;
    reg mclk = 1'b0;
    wire arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    wire rvalid, rready, outReady;
    wire [7:0] awaddr, araddr;
    wire [31:0] wdata, rdata;
    wire [3:0] wstrb;
    wire [1:0] bresp, rresp;
    wire [13:0] dacCode;
    integer errTotal = 0, testsRun = 0, n;
    initial forever #10 mclk = ~mclk;
    drs_reset_sequencer u_dut (.*);
    drs_host u_host (.*);
    task printVerdict;
        begin
            errTotal = errTotal + u_host.hang;
            if (errTotal == 0 && testsRun > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // one bus transfer judged on response, and on data for reads
    task x(input wrOp, input [7:0] a, input [31:0] d, input [1:0] er);
        reg [31:0] q;
        reg [1:0] rs;
        begin
            u_host.xfer(wrOp, a, d, q, rs);
            if (u_host.hang) printVerdict;
            `CHK("resp", er, rs)
            if (!wrOp) `CHK("rdata", d, q)
        end
    endtask
    // reset, then count edges until the output goes live
    task scnReset;
        begin
            u_host.rst;
            for (n = 0; !outReady && n < 20; n = n + 1) begin
                `CHK("dacCode", 14'h2000, dacCode)
                @(posedge mclk);
                #1;
            end
            `CHK("liveEdge", 11, n)
        end
    endtask
    // register defaults
    task scnDefaults;
        begin
            x(0, `DRS_OFF_CF_LO, 32'h0, 2'h0);
            x(0, `DRS_OFF_CF_HI, 32'h4000, 2'h0);
            x(0, `DRS_OFF_CFG13, 32'h40, 2'h0);
            x(0, `DRS_OFF_CFG14, 32'h0, 2'h0);
            x(0, `DRS_OFF_STAT, 32'h3B, 2'h0);
        end
    endtask
    // host set-up after reset and an upper centre word
    task scnInit;
        begin
            x(1, `DRS_OFF_CFG14, 32'h30, 2'h0);
            x(0, `DRS_OFF_CFG14, 32'h30, 2'h0);
            x(1, `DRS_OFF_CFG13, 32'h80, 2'h0);
            x(0, `DRS_OFF_CFG13, 32'h80, 2'h0);
            // zeroed words survive the next reset, so the tone is defined then
            x(1, `DRS_OFF_OF_LO, 32'h0, 2'h0);
            x(1, `DRS_OFF_OF_HI, 32'h0, 2'h0);
            x(1, `DRS_OFF_SF_LO, 32'h0, 2'h0);
            x(1, `DRS_OFF_SF_HI, 32'h0, 2'h0);
            x(0, `DRS_OFF_SF_HI, 32'h0, 2'h0);
            x(1, `DRS_OFF_CF_HI, 32'h8001, 2'h0);
            x(0, `DRS_OFF_CF_HI, 32'h8001, 2'h0);
        end
    endtask
    // quarter-rate centre word: a new sample each cycle, period of four
    task scnTone;
        reg [13:0] s [0:7];
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                @(posedge mclk);
                #1;
                s[i] = dacCode;
            end
            for (i = 0; i < 4; i = i + 1) begin
                `CHK("dacPeriod", s[i], s[i + 4])
                `CHK("dacStep", 1'b1, s[i] != s[i + 1])
            end
        end
    endtask
    // write raised in reset: taken at edge 2, answered edge 3, acked edge 5
    task scnEarly;
        reg [1:0] rs;
        begin
            u_host.rstWrite(`DRS_OFF_CFG14, 32'h30, rs);
            if (u_host.hang) printVerdict;
            `CHK("earlyResp", 2'h0, rs)
            `CHK("earlyEdge", 5, u_host.n)
            x(0, `DRS_OFF_CFG14, 32'h30, 2'h0);
        end
    endtask
    // unmapped and read-only places refuse
    task scnErr;
        begin
            x(0, 8'h24, 32'h0, 2'h2);
            x(1, 8'h24, 32'h1, 2'h2);
            x(1, `DRS_OFF_STAT, 32'h0, 2'h2);
            x(0, `DRS_OFF_STAT, 32'h3B, 2'h0);
        end
    endtask
    initial begin
        scnReset;
        scnDefaults;
        scnInit;
        scnErr;
        scnReset; // second reset must undo the centre and config writes
        scnTone;
        scnDefaults;
        x(1, `DRS_OFF_CFG14, 32'h0, 2'h0);
        scnEarly;
        printVerdict;
    end
endmodule // drs_reset_sequencer_tb
